// ===== design/tdm_pkg.sv
// Purpose: Constants for the shared text display message codec.
// Assumes: One 20 MHz clock; link framing is done outside.
// Notes: Register offsets are byte addresses on AXI4-Lite.
// Notes on behaviour
// R1: Capability message uses identifier 227, length three.
// R2: Send capability at power-up and on request.
// R3: Config bits 8-5 report current language.
// R4: English text is always displayable.
// R5: Config bits 4 and 3 are zero.
// R6: Config bit 2 flags operator key.
// R7: Config bit 1 flags beeper.
// R8: Bytes two, three give rows, columns.
// R9: Text arrives under 226, fixed byte order.
// R10: Status1 bit 8 forces English text.
// R11: Status1 bit 7 discards sender buffer.
// R12: Status1 bit 6 selects stored message.
// R13: Status1 bit 5 shows buffer, else append.
// R14: Status1 bit 4 sounds beeper, own time.
// R15: Status1 bit 3 acks after display.
// R16: Status1 bit 2 acks after operator key.
// R17: Status1 bit 1 acks each section immediately.
// R18: Status2 bits 8-4 are display seconds.
// R19: Status2 bits 3-1 are priority.
// R20: Row byte is target line, top one.
// R21: Column byte is start column, left one.
// R22: Following bytes are ASCII characters.
// R23: One buffer per sender, twenty at least.
// R24: Acknowledge to the sending unit only.
// R25: Unsupported language code reads as English.
package tdm_pkg;
  // ------------------------------------------------------------
  // Message layout
  // ------------------------------------------------------------
  localparam logic [7:0] PID_TEXT  = 8'hE2;
  localparam logic [7:0] PID_CAP   = 8'hE3;
  localparam logic [7:0] CAP_LEN   = 8'h03;
  localparam logic [3:0] MSG_PRIO  = 4'h8;
  localparam logic [3:0] LANG_ENG  = 4'h0;
  localparam int         LANG_N    = 5;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_GEOM  = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_BUF   = 8'h0C;
  localparam logic [7:0] OFS_OPACK = 8'h10;
  localparam logic [7:0] RST_ROWS  = 8'h02;
  localparam logic [7:0] RST_COLS  = 8'h14;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  // ------------------------------------------------------------
  // Acknowledgment kinds and timing
  // ------------------------------------------------------------
  localparam logic [1:0] ACK_RCPT  = 2'h0;
  localparam logic [1:0] ACK_DISP  = 2'h1;
  localparam logic [1:0] ACK_OPER  = 2'h2;
  localparam int         CLK_HZ    = 20000000;
  localparam int         BEEP_MS   = 500;
  localparam int         BEEP_CYC  = CLK_HZ / 1000 * BEEP_MS;
  typedef enum logic [2:0] {
    RX_IDLE, RX_LEN, RX_ST1, RX_ST2, RX_ROW, RX_COL, RX_TXT, RX_SKIP
  } tdm_rx_t;
endpackage : tdm_pkg

// ===== design/tdm_codec.sv
// Purpose: Display side codec for capability and text messages.
// Assumes: Link layer hands over bytes with a sender slot and MID.
// Notes: Rendering is outside; buffers are readable over the bus.
`timescale 1ns/1ps
`default_nettype none
module tdm_codec
  import tdm_pkg::*;
#(
  parameter int NSRC     = 20,
  parameter int BUF_LEN  = 80,
  parameter int BEEP_LEN = tdm_pkg::BEEP_CYC,
  parameter logic [LANG_N-1:0] LANG_OK = 5'h01
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_first,
  input  wire logic [4:0]  rx_slot,
  input  wire logic [7:0]  rx_mid,
  input  wire logic        cap_req,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_byte,
  output logic             tx_last,
  output logic [3:0]       tx_prio,
  output logic             ack_valid,
  input  wire logic        ack_ready,
  output logic [1:0]       ack_kind,
  output logic [7:0]       ack_mid,
  output logic             show_valid,
  output logic [4:0]       show_slot,
  output logic             show_english,
  output logic             show_predef,
  output logic [4:0]       show_secs,
  output logic [2:0]       show_prio,
  output logic [7:0]       show_row,
  output logic [7:0]       show_col,
  output logic [7:0]       show_len,
  output logic             beep_on
);
  import tdm_pkg::*;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [3:0]  lang_reg;
  logic        key_reg;
  logic        beeper_reg;
  logic [7:0]  rows_reg;
  logic [7:0]  cols_reg;
  logic        wr_go;
  logic [7:0]  wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [4:0]  sel_slot_reg;
  logic [7:0]  sel_idx_reg;

  function automatic logic lang_known(input logic [3:0] l);
    lang_known = (l < 4'(LANG_N)) && LANG_OK[l[2:0]];
  endfunction : lang_known

  // Reserved or unsupported codes fall back to English.
  logic [3:0] lang_eff;
  assign lang_eff = lang_known(lang_reg) ? lang_reg : LANG_ENG; // R25 R4

  // ------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign wr_go         = aw_have_reg && w_have_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      wr_addr_reg  <= 8'h00;
      wr_data_reg  <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg  <= 1'b1;
        wr_data_reg <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr_reg <= OFS_OPACK
                         && wr_addr_reg[1:0] == 2'h0) ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Byte strobe 0 gates every write; lane 1 of GEOM and BUF also needs strobe 1.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lang_reg     <= LANG_ENG;
      key_reg      <= 1'b0;
      beeper_reg   <= 1'b0;
      rows_reg     <= RST_ROWS;
      cols_reg     <= RST_COLS;
      sel_slot_reg <= 5'h00;
      sel_idx_reg  <= 8'h00;
    end
    else if (wr_go && s_axi_wstrb[0])
    begin
      case (wr_addr_reg)
        OFS_CTRL:
        begin
          lang_reg   <= wr_data_reg[7:4];
          key_reg    <= wr_data_reg[1];
          beeper_reg <= wr_data_reg[0];
        end
        OFS_GEOM:
        begin
          rows_reg <= wr_data_reg[7:0];
          if (s_axi_wstrb[1])
            cols_reg <= wr_data_reg[15:8];
        end
        OFS_BUF:
        begin
          sel_slot_reg <= wr_data_reg[4:0];
          if (s_axi_wstrb[1])
            sel_idx_reg <= wr_data_reg[15:8];
        end
        default:
          sel_idx_reg <= sel_idx_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Capability transmitter
  // ------------------------------------------------------------
  logic       cap_pend_reg;
  logic       cap_busy_reg;
  logic [2:0] cap_idx_reg;
  logic       cap_sw;

  assign cap_sw = wr_go && s_axi_wstrb[0] && wr_addr_reg == OFS_CTRL
                  && wr_data_reg[8];

  function automatic logic [7:0] cap_byte(input logic [2:0] i,
                                           input logic [3:0] l,
                                           input logic k,
                                           input logic b,
                                           input logic [7:0] r,
                                           input logic [7:0] c);
    case (i)
      3'h0:    cap_byte = PID_CAP;
      3'h1:    cap_byte = CAP_LEN;
      3'h2:    cap_byte = {l, 2'b00, k, b};
      3'h3:    cap_byte = r;
      default: cap_byte = c;
    endcase
  endfunction : cap_byte

  // A pending flag survives a request arriving mid-send.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cap_pend_reg <= 1'b1; // R2
      cap_busy_reg <= 1'b0;
      cap_idx_reg  <= 3'h0;
    end
    else
    begin
      if (!cap_busy_reg && cap_pend_reg)
      begin
        cap_busy_reg <= 1'b1;
        cap_idx_reg  <= 3'h0;
      end
      else if (cap_busy_reg && tx_ready)
      begin
        cap_idx_reg <= cap_idx_reg + 3'h1;
        if (tx_last)
          cap_busy_reg <= 1'b0;
      end
      if (cap_req || cap_sw)
        cap_pend_reg <= 1'b1; // R2
      else if (!cap_busy_reg && cap_pend_reg)
        cap_pend_reg <= 1'b0;
    end
  end

  assign tx_valid = cap_busy_reg;
  assign tx_last  = cap_idx_reg == 3'h4; // R1
  assign tx_prio  = MSG_PRIO; // R2
  assign tx_byte  = cap_byte(cap_idx_reg, lang_eff, key_reg, // R1 R3 R5
                             beeper_reg, rows_reg, cols_reg); // R6 R7 R8

  // ------------------------------------------------------------
  // Text message parser
  // ------------------------------------------------------------
  tdm_rx_t     rx_st;
  logic [7:0]  cnt_reg;
  logic [7:0]  st1_reg;
  logic [7:0]  st2_reg;
  logic [4:0]  slot_reg;
  logic        fin_reg;
  logic        rx_take;
  logic [7:0]  buf_mem [NSRC*BUF_LEN];
  logic [7:0]  ptr_reg [NSRC];
  logic [7:0]  row_reg [NSRC];
  logic [7:0]  col_reg [NSRC];
  logic [7:0]  mid_reg [NSRC];
  logic        rcpt_p_reg;
  logic        disp_p_reg;
  logic        op_go_reg;
  logic [4:0]  ack_slot_reg;
  logic [4:0]  op_slot_reg;
  logic [NSRC-1:0] op_wait_reg;

  function automatic int unsigned slot_at(input logic [4:0] s,
                                          input logic [7:0] p);
    slot_at = int'(s) * BUF_LEN + int'(p);
  endfunction : slot_at

  assign rx_take  = rx_valid && rx_ready;
  assign rx_ready = !fin_reg && !ack_valid; // R24

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_st    <= RX_IDLE;
      cnt_reg  <= 8'h00;
      st1_reg  <= 8'h00;
      st2_reg  <= 8'h00;
      slot_reg <= 5'h00;
      fin_reg  <= 1'b0;
    end
    else
    begin
      fin_reg <= 1'b0;
      if (rx_take && rx_first)
      begin
        rx_st    <= (rx_byte == PID_TEXT) ? RX_LEN : RX_SKIP; // R9
        slot_reg <= rx_slot; // R23
      end
      else if (rx_take)
      begin
        case (rx_st)
          RX_LEN:
          begin
            cnt_reg <= rx_byte;
            rx_st   <= (rx_byte == 8'h00) ? RX_IDLE : RX_ST1;
          end
          RX_ST1, RX_ST2, RX_ROW, RX_COL, RX_TXT:
          begin
            cnt_reg <= cnt_reg - 8'h01;
            if (rx_st == RX_ST1)
              st1_reg <= rx_byte; // R9
            if (rx_st == RX_ST2)
              st2_reg <= rx_byte;
            if (cnt_reg == 8'h01)
            begin
              fin_reg <= 1'b1;
              rx_st   <= RX_IDLE;
            end
            else if (rx_st != RX_TXT)
              rx_st <= tdm_rx_t'(rx_st + 3'h1);
          end
          default:
            rx_st <= rx_st;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Per-sender buffers
  // ------------------------------------------------------------
  logic complete;
  assign complete = fin_reg && !st1_reg[6] && st1_reg[4];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NSRC; i++)
      begin
        ptr_reg[i] <= 8'h00;
        row_reg[i] <= 8'h01;
        col_reg[i] <= 8'h01;
        mid_reg[i] <= 8'h00;
      end
    end
    else if (fin_reg && (st1_reg[6] || st1_reg[4]))
      ptr_reg[slot_reg] <= 8'h00; // R11 R13
    else if (rx_take && !rx_first)
    begin
      mid_reg[slot_reg] <= rx_mid; // R24
      if (rx_st == RX_ROW && ptr_reg[slot_reg] == 8'h00)
        row_reg[slot_reg] <= rx_byte; // R20
      if (rx_st == RX_COL && ptr_reg[slot_reg] == 8'h00)
        col_reg[slot_reg] <= rx_byte; // R21
      if (rx_st == RX_TXT && ptr_reg[slot_reg] < 8'(BUF_LEN))
        ptr_reg[slot_reg] <= ptr_reg[slot_reg] + 8'h01; // R13
    end
  end

  // Characters past the buffer end are dropped, not wrapped.
  always_ff @(posedge aclk)
  begin
    if (rx_take && !rx_first && rx_st == RX_TXT
        && ptr_reg[slot_reg] < 8'(BUF_LEN))
      buf_mem[slot_at(slot_reg, ptr_reg[slot_reg])] <= rx_byte; // R22
  end

  // ------------------------------------------------------------
  // Display event and beeper
  // ------------------------------------------------------------
  logic [31:0] beep_cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      show_valid   <= 1'b0;
      show_slot    <= 5'h00;
      show_english <= 1'b1;
      show_predef  <= 1'b0;
      show_secs    <= 5'h00;
      show_prio    <= 3'h0;
      show_row     <= 8'h01;
      show_col     <= 8'h01;
      show_len     <= 8'h00;
    end
    else
    begin
      show_valid <= complete; // R13
      if (complete)
      begin
        show_slot    <= slot_reg;
        show_english <= st1_reg[7] || lang_eff == LANG_ENG; // R10 R25
        show_predef  <= st1_reg[5]; // R12
        show_secs    <= st2_reg[7:3]; // R18
        show_prio    <= st2_reg[2:0]; // R19
        show_row     <= row_reg[slot_reg];
        show_col     <= col_reg[slot_reg];
        show_len     <= ptr_reg[slot_reg];
      end
    end
  end

  // The beeper length is fixed here; the sender cannot set it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      beep_cnt_reg <= 32'h0000_0000;
    else if (complete && st1_reg[3] && beeper_reg)
      beep_cnt_reg <= 32'(BEEP_LEN); // R14
    else if (beep_cnt_reg != 32'h0000_0000)
      beep_cnt_reg <= beep_cnt_reg - 32'h0000_0001;
  end
  assign beep_on = beep_cnt_reg != 32'h0000_0000;

  // ------------------------------------------------------------
  // Acknowledgment scheduler
  // ------------------------------------------------------------
  logic op_sw;
  assign op_sw = wr_go && s_axi_wstrb[0] && wr_addr_reg == OFS_OPACK;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rcpt_p_reg   <= 1'b0;
      disp_p_reg   <= 1'b0;
      op_go_reg    <= 1'b0;
      ack_slot_reg <= 5'h00;
      op_slot_reg  <= 5'h00;
      op_wait_reg  <= '0;
    end
    else
    begin
      if (ack_valid && ack_ready)
      begin
        if (rcpt_p_reg)
          rcpt_p_reg <= 1'b0;
        else if (disp_p_reg)
          disp_p_reg <= 1'b0;
        else
          op_go_reg <= 1'b0;
      end
      if (op_sw && !op_go_reg && op_wait_reg[wr_data_reg[4:0]])
      begin
        op_go_reg   <= 1'b1; // R16
        op_slot_reg <= wr_data_reg[4:0];
        op_wait_reg[wr_data_reg[4:0]] <= 1'b0;
      end
      if (fin_reg)
      begin
        ack_slot_reg <= slot_reg; // R24
        rcpt_p_reg   <= st1_reg[0]; // R17
        disp_p_reg   <= complete && st1_reg[2]; // R15
        if (complete && st1_reg[1] && key_reg)
          op_wait_reg[slot_reg] <= 1'b1; // R16
        if (st1_reg[6])
          op_wait_reg[slot_reg] <= 1'b0; // R11
      end
    end
  end

  assign ack_valid = rcpt_p_reg || disp_p_reg || op_go_reg;
  assign ack_kind  = rcpt_p_reg ? ACK_RCPT
                   : (disp_p_reg ? ACK_DISP : ACK_OPER);
  assign ack_mid   = (rcpt_p_reg || disp_p_reg) ? mid_reg[ack_slot_reg]
                                                : mid_reg[op_slot_reg];

  // ------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OK;
      case (s_axi_araddr)
        OFS_CTRL:
          s_axi_rdata <= {23'h0, cap_pend_reg || cap_busy_reg,
                          lang_eff, 2'b00, key_reg, beeper_reg};
        OFS_GEOM:
          s_axi_rdata <= {16'h0000, cols_reg, rows_reg};
        OFS_STAT:
          s_axi_rdata <= {beep_on, show_english, show_predef,
                          show_slot, show_secs, show_prio,
                          show_row, show_col};
        OFS_BUF:
          s_axi_rdata <= {8'h00, ptr_reg[sel_slot_reg],
                          sel_idx_reg,
                          (sel_idx_reg < 8'(BUF_LEN))
                          ? buf_mem[slot_at(sel_slot_reg, sel_idx_reg)]
                          : 8'h00};
        OFS_OPACK:
          s_axi_rdata <= 32'(op_wait_reg);
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_cap_head;
    @(posedge aclk) disable iff (!aresetn)
    tx_valid && cap_idx_reg == 3'h0
    |-> tx_byte == PID_CAP ##0 tx_prio == MSG_PRIO;
  endproperty
  a_cap_head: assert property (p_cap_head) // R1
    else $error("capability message does not start with its id");

  property p_cap_len;
    @(posedge aclk) disable iff (!aresetn)
    tx_valid && tx_ready && cap_idx_reg == 3'h0
    |=> tx_byte == CAP_LEN ##0 !tx_last;
  endproperty
  a_cap_len: assert property (p_cap_len) // R1
    else $error("capability length byte wrong");

  property p_cap_boot;
    @(posedge aclk)
    $rose(aresetn) |-> ##1 tx_valid;
  endproperty
  a_cap_boot: assert property (p_cap_boot) // R2
    else $error("no capability message after reset");

  property p_cfg_bits;
    @(posedge aclk) disable iff (!aresetn)
    tx_valid && cap_idx_reg == 3'h2
    |-> tx_byte[3:2] == 2'b00 && tx_byte[1] == key_reg
        && tx_byte[0] == beeper_reg;
  endproperty
  a_cfg_bits: assert property (p_cfg_bits) // R5
    else $error("configuration byte flags wrong");

  property p_lang;
    @(posedge aclk) disable iff (!aresetn)
    tx_valid && cap_idx_reg == 3'h2 && !lang_known(lang_reg)
    |-> tx_byte[7:4] == LANG_ENG;
  endproperty
  a_lang: assert property (p_lang) // R25
    else $error("unsupported language not reported as English");

  property p_show;
    @(posedge aclk) disable iff (!aresetn)
    fin_reg && st1_reg[4] && !st1_reg[6] |=> show_valid;
  endproperty
  a_show: assert property (p_show) // R13
    else $error("complete message not shown");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
    fin_reg && st1_reg[6] |=> !show_valid && ptr_reg[$past(slot_reg)] == 0;
  endproperty
  a_abort: assert property (p_abort) // R11
    else $error("aborted buffer not discarded");

  property p_rcpt;
    @(posedge aclk) disable iff (!aresetn)
    fin_reg && st1_reg[0]
    |=> ack_valid && ack_kind == ACK_RCPT;
  endproperty
  a_rcpt: assert property (p_rcpt) // R17
    else $error("receipt acknowledgment missing");
endmodule : tdm_codec
`default_nettype wire

// ===== verif/tdm_link_model.sv
// Purpose: Far side of the text link.
// Assumes: Same clock as the codec.
// Notes: Ready lines stall on alternate cycles.
`timescale 1ns/1ps
`default_nettype none
module tdm_link_model (
  input  wire logic       aclk,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_byte,
  output logic            rx_first,
  output logic [4:0]      rx_slot,
  output logic [7:0]      rx_mid,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_byte,
  input  wire logic       ack_valid,
  output logic            ack_ready,
  input  wire logic [1:0] ack_kind,
  input  wire logic [7:0] ack_mid
);
  logic [7:0] txq[$];
  logic [7:0] last_mid;
  int         n_ack[4];
  int         hung;
  initial
  begin
    {rx_valid, rx_first, rx_slot, rx_mid, rx_byte} = '0;
    {tx_ready, ack_ready} = 2'b10;
    hung = 0;
  end
  // A stalled ready shows outputs that move before they are taken.
  always @(posedge aclk)
  begin
    if (tx_valid && tx_ready) txq.push_back(tx_byte);
    if (ack_valid && ack_ready)
    begin
      n_ack[ack_kind]++;
      last_mid = ack_mid;
    end
    tx_ready  <= ~tx_ready;
    ack_ready <= ~ack_ready;
  end
  task automatic send(input logic [4:0] s, input logic [7:0] m,
                      input logic [7:0] b[$]);
    int k;
    foreach (b[i])
    begin
      rx_valid <= 1'b1;
      rx_byte  <= b[i];
      rx_first <= (i == 0);
      rx_slot  <= s;
      rx_mid   <= m;
      for (k = 0; k < 500; k++)
      begin
        @(negedge aclk);
        if (rx_ready) break;
      end
      hung += (k == 500);
      @(posedge aclk);
    end
    rx_valid <= 1'b0;
    rx_byte  <= ~b[b.size()-1];
    @(posedge aclk);
  endtask : send
endmodule : tdm_link_model
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench for the display codec.
// Assumes: Link model on the far side.
// Notes: Beep time cut to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, s); end end
module tb;
  import tdm_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, rx_valid, rx_ready;
  logic rx_first, cap_req, tx_valid, tx_ready, tx_last, ack_valid;
  logic ack_ready, show_valid, show_english, show_predef, beep_on;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ack_kind, rr;
  logic [3:0]  tx_prio;
  logic [4:0]  rx_slot, show_slot, show_secs;
  logic [2:0]  show_prio;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_byte, rx_mid, tx_byte;
  logic [7:0]  ack_mid, show_row, show_col, show_len;
  logic [31:0] s_axi_wdata, s_axi_rdata, rq;
  int          errors, n_tests, n_show, n_beep;
  // Rows: control word, geometry word, capability configuration byte.
  logic [39:0] cap_tab[6] = '{40'h0103011003, 40'h0112FF0012,
    40'h012100FF21, 40'h0130281430, 40'h01F3011003,
    40'h0143040243};
  tdm_codec #(.BEEP_LEN(20), .LANG_OK(5'h1F)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_ready, .rx_byte,
    .rx_first, .rx_slot, .rx_mid, .cap_req, .tx_valid, .tx_ready,
    .tx_byte, .tx_last, .tx_prio, .ack_valid, .ack_ready, .ack_kind,
    .ack_mid, .show_valid, .show_slot, .show_english, .show_predef,
    .show_secs, .show_prio, .show_row, .show_col, .show_len, .beep_on);
  tdm_link_model p (.aclk, .rx_valid, .rx_ready, .rx_byte, .rx_first,
    .rx_slot, .rx_mid, .tx_valid, .tx_ready, .tx_byte, .ack_valid,
    .ack_ready, .ack_kind, .ack_mid);
  initial
  begin
    aclk = 0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    n_show += (show_valid === 1'b1);
    n_beep += (beep_on === 1'b1);
  end
  task automatic stop_test;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // ------------------------------------------------------------
  // Bus master: ready and answer are sampled at the falling edge.
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    logic aw, w, ar, f;
    int k;
    f = 0;
    s_axi_awaddr <= a; s_axi_araddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= wr; s_axi_wvalid <= wr; s_axi_bready <= wr;
    s_axi_arvalid <= !wr; s_axi_rready <= !wr;
    for (k = 0; k < 100 && !f; k++)
    begin
      @(negedge aclk);
      {aw, w, ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
      f = wr ? s_axi_bvalid : s_axi_rvalid;
      rq = s_axi_rdata;
      rr = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      if (ar) s_axi_arvalid <= 0;
    end
    s_axi_bready <= 0; s_axi_rready <= 0;
    if (!f) begin errors++; stop_test(); end
    @(posedge aclk);
  endtask : bus
  function automatic int cnt(input int w);
    return w == 0 ? n_show : w == 1 ? p.txq.size() : p.n_ack[w-2];
  endfunction : cnt
  task automatic waitn(input int w, input int n);
    int k;
    for (k = 0; k < 300 && cnt(w) < n; k++) @(posedge aclk);
    if (cnt(w) < n) begin errors++; stop_test(); end
  endtask : waitn
  task automatic chkcap(input logic [7:0] c, r, k);
    waitn(1, 5);
    `CHK("cap pid", PID_CAP, p.txq[0])
    `CHK("cap len", CAP_LEN, p.txq[1])
    `CHK("cap cfg", c, p.txq[2])
    `CHK("cap rows", r, p.txq[3])
    `CHK("cap cols", k, p.txq[4])
    p.txq.delete();
  endtask : chkcap
  initial
  begin
    {aresetn, cap_req, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    {errors, n_tests, n_show, n_beep} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    waitn(1, 5);
    `CHK("boot pid", PID_CAP, p.txq[0])
    `CHK("boot rsv", 2'b00, p.txq[2][3:2])
    `CHK("boot rows", RST_ROWS, p.txq[3])
    `CHK("prio", MSG_PRIO, tx_prio)
    p.txq.delete();
    foreach (cap_tab[i])
    begin
      bus(1, OFS_GEOM, {16'h0, cap_tab[i][23:8]});
      bus(1, OFS_CTRL, {16'h0, cap_tab[i][39:24]});
      chkcap(cap_tab[i][7:0], cap_tab[i][15:8], cap_tab[i][23:16]);
    end
    cap_req <= 1'b1;
    @(posedge aclk);
    cap_req <= 1'b0;
    chkcap(8'h43, 8'h02, 8'h04);
    bus(0, 8'h40, 0);
    `CHK("unmapped", RESP_ERR, rr)
    p.send(1, 8'hB5, '{PID_TEXT, 6, 8'h01, 8'hF0, 1, 1, 8'h4A, 8'h6F});
    waitn(2, 1);
    `CHK("rcpt mid", 8'hB5, p.last_mid)
    p.send(1, 8'hB5, '{PID_TEXT, 5, 8'h9D, 8'h0B, 2, 5, 8'h65});
    waitn(0, 1);
    `CHK("show", 23'h060B03, {show_slot, show_english, show_predef,
      show_secs, show_prio, show_len})
    `CHK("pos", 16'h0101, {show_row, show_col})
    bus(1, OFS_BUF, 32'h0000_0201);
    bus(0, OFS_BUF, 0);
    `CHK("char", 32'h0000_0265, rq)
    waitn(3, 1);
    `CHK("rcpt n", 2, p.n_ack[0])
    repeat (40) @(posedge aclk);
    `CHK("beep", 20, n_beep)
    p.send(3, 8'h33, '{PID_TEXT, 6, 8'h00, 8'h00, 1, 1, 8'h41, 8'h42});
    p.send(3, 8'h33, '{PID_TEXT, 4, 8'h50, 8'h00, 1, 1});
    repeat (20) @(posedge aclk);
    `CHK("abort", 1, n_show)
    p.send(3, 8'h33, '{PID_TEXT, 5, 8'h10, 8'h00, 4, 2, 8'h5A});
    waitn(0, 2);
    `CHK("after abort", 24'h040201, {show_row, show_col, show_len})
    p.send(4, 8'h44, '{PID_TEXT, 5, 8'h30, 8'h00, 1, 1, 8'h07});
    waitn(0, 3);
    `CHK("predef", 2'b01, {show_english, show_predef})
    p.send(5, 8'h42, '{PID_TEXT, 5, 8'h12, 8'h00, 1, 1, 8'h58});
    waitn(0, 4);
    repeat (10) @(posedge aclk);
    `CHK("no oper", 0, p.n_ack[2])
    bus(1, OFS_OPACK, 5);
    `CHK("wresp", RESP_OK, rr)
    waitn(4, 1);
    `CHK("oper mid", 8'h42, p.last_mid)
    `CHK("hung", 0, p.hung)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("rst tx", 0, tx_valid)
    aresetn <= 1'b1;
    waitn(1, 5);
    `CHK("rst cap", {8'h00, RST_ROWS, RST_COLS},
      {p.txq[2], p.txq[3], p.txq[4]})
    stop_test();
  end
endmodule : tb
`default_nettype wire
